// File: pkg/monitor_pkg.sv
// Constants and carrier types for the heatseal supervision and alarm block
package monitor_pkg;
  // Clock and tick base
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned FAST_HALF_MS = 125;
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned FAST_HALF_CYCLES = CLK_HZ / 1000 * FAST_HALF_MS;
  localparam int unsigned SLOW_HALF_CYCLES = CLK_HZ / 1000 * SLOW_HALF_MS;
  // Durations in ticks of 0.1 s
  localparam int unsigned HOLD_EXT_MS = 2000;
  localparam int unsigned COMP_WINDOW_MS = 2000;
  localparam int unsigned COMP_RUN_MS = 2000;
  localparam logic [7:0] HOLD_EXT_TICKS = 8'(HOLD_EXT_MS / TICK_MS);
  localparam logic [7:0] COMP_WINDOW_TICKS = 8'(COMP_WINDOW_MS / TICK_MS);
  localparam logic [7:0] COMP_RUN_TICKS = 8'(COMP_RUN_MS / TICK_MS);
  localparam logic [7:0] HEAT_BLINK_TICKS = 8'h02;
  // Measuring pulse, in microseconds
  localparam int unsigned MEAS_PULSE_US = 1700;
  localparam logic [15:0] MEAS_PULSE_CYCLES_RST = 16'(CLK_HZ / 1000000 * MEAS_PULSE_US);
  localparam int unsigned MEAS_PERIOD_MS = 20;
  localparam int unsigned MEAS_PERIOD_CYCLES = CLK_HZ / 1000 * MEAS_PERIOD_MS;
  // Register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_BAND = 4'h1;
  localparam logic [3:0] REG_DIAG_DELAY = 4'h2;
  localparam logic [3:0] REG_HEAT_TIMEOUT = 4'h3;
  localparam logic [3:0] REG_MEAS_PULSE = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;
  localparam logic [3:0] REG_DISPLAY = 4'h6;
  // Control register fields
  localparam int unsigned CTRL_HOLD_LSB = 0;
  localparam int unsigned CTRL_COMP_EN = 2;
  localparam int unsigned CTRL_DIAG_EN = 3;
  localparam int unsigned CTRL_HEATUP_EN = 4;
  localparam int unsigned CTRL_RELAY_INV = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // Band defaults in kelvin
  localparam logic [7:0] BAND_LOWER_RST = 8'h0a;
  localparam logic [7:0] BAND_UPPER_RST = 8'h0a;
  localparam logic [6:0] DIAG_DELAY_MAX = 7'h63;
  localparam logic [15:0] HEAT_TIMEOUT_RST = 16'h0032;
  // Error codes
  localparam logic [9:0] ERR_NONE = 10'h000;
  localparam logic [9:0] ERR_HEATUP = 10'd304;
  localparam logic [9:0] ERR_LOW = 10'd307;
  localparam logic [9:0] ERR_HIGH = 10'd308;
  localparam logic [9:0] ERR_NOARM_LOW = 10'd309;
  localparam logic [9:0] ERR_NOARM_HIGH = 10'd310;

  typedef enum logic [1:0] {
    HOLD_OFF = 2'h0,
    HOLD_ON = 2'h1,
    EXTENDED_HOLD = 2'h2
  } hold_setting_t;

  typedef enum logic [1:0] {
    LAMP_OFF = 2'h0,
    LAMP_FAST = 2'h1,
    LAMP_SLOW = 2'h2,
    LAMP_STEADY = 2'h3
  } lamp_class_t;

  typedef enum logic [3:0] {
    COMP_IDLE = 4'b0001,
    COMP_WINDOW = 4'b0010,
    COMP_RUN = 4'b0100,
    COMP_HOME = 4'b1000
  } comp_state_t;

  typedef struct packed {
    logic [9:0] code;
    logic comp_window_prompt;
    logic [2:0] dots;
    logic [9:0] temp;
  } display_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// File: hdl/heatseal_monitor_alarm.sv
// Supervision, hold display, phase compensation and alarm indication logic
// Contract
// - Extended hold shows end-of-phase temperature two more seconds, then real time.
// - Hold affects display only; analog output tracks real-time temperature.
// - Measuring pulse length configurable, default 1.7 ms, via diagnostic registers.
// - After good zero calibration, 2.0 s prompt window; enter starts compensation.
// - Window expiry without enter returns display home, skips compensation.
// - Compensation runs about 2.0 s with prompt and dots lighting in turn.
// - During compensation heating lamp blinks, analog output forced to bottom.
// - Compensation gated by enable bit, reset disabled; disabled means no window.
// - Diagnosis band around setpoint, lower and upper offsets default 10 K.
// - Diagnosis arms when start asserts with temperature inside band.
// - Armed and temperature leaves band: error 307 or 308, alarm relay.
// - Not armed when start deasserts: error 309 or 310, alarm relay.
// - Delay 0..9.9 s postpones arming after first lower-limit crossing.
// - Heatup timer runs from start until temperature reaches 95% setpoint.
// - Heatup time over configured timeout flags error 304 and relay.
// - Active fault's numeric code shown on terminal display.
// - Lamp blinks 1 Hz for configuration faults 111-114.
// - Lamp steady for startup-blocking faults incl. 307-310, 801, 9xx.
// - Start during a blinking fault turns the lamp steady.
// - Alarm clears only by reset key, effective on key release, or power cycle.
// - Relay off for blink classes, on with start or steady class; option inverts.
module heatseal_monitor_alarm #(
  parameter int unsigned TEMP_W = 10,
  parameter int unsigned TICK_LEN = monitor_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start_pin,
  input wire logic enter_key,
  input wire logic reset_key,
  input wire logic [TEMP_W-1:0] actual_temp,
  input wire logic [TEMP_W-1:0] set_temp,
  input wire logic phase_end,
  input wire logic zero_calibration_ok,
  input wire logic [9:0] ext_fault_code,
  input wire logic ext_fault_valid,
  input wire monitor_pkg::reg_req_t req,
  output logic [15:0] rdata,
  output monitor_pkg::display_t display,
  output logic [TEMP_W-1:0] analog_out,
  output logic meas_pulse,
  output logic heat_lamp,
  output logic alarm_lamp,
  output logic alarm_relay
);
  if (TEMP_W < 8 || TEMP_W > 10) $error("TEMP_W must be 8..10");
  if (TICK_LEN < 2) $error("TICK_LEN too small");

  // Two-stage synchronisers for pins
  logic [2:0] sync1;
  logic [2:0] sync2;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
    end else begin
      sync1 <= {reset_key, enter_key, start_pin};
      sync2 <= sync1;
    end
  end
  logic start;
  logic enter;
  logic rkey;
  assign start = sync2[0];
  assign enter = sync2[1];
  assign rkey = sync2[2];
  logic start_d;
  logic enter_d;
  logic rkey_d;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      start_d <= 1'b0;
      enter_d <= 1'b0;
      rkey_d <= 1'b0;
    end else begin
      start_d <= start;
      enter_d <= enter;
      rkey_d <= rkey;
    end
  end
  logic start_rise;
  logic start_fall;
  logic enter_press;
  logic rkey_release;
  assign start_rise = start && !start_d;
  assign start_fall = !start && start_d;
  assign enter_press = enter && !enter_d;
  assign rkey_release = !rkey && rkey_d;

  // Common 0.1 s tick
  logic [31:0] tick_cnt;
  logic tick;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
    end else if (tick_cnt == 32'(TICK_LEN - 1)) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign tick = (tick_cnt == 32'(TICK_LEN - 1));

  // Configuration registers
  logic [5:0] ctrl;
  logic [7:0] band_lower;
  logic [7:0] band_upper;
  logic [6:0] diag_delay;
  logic [15:0] heat_timeout;
  logic [15:0] meas_len;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl <= monitor_pkg::CTRL_RST;
      band_lower <= monitor_pkg::BAND_LOWER_RST;
      band_upper <= monitor_pkg::BAND_UPPER_RST;
      diag_delay <= 7'h00;
      heat_timeout <= monitor_pkg::HEAT_TIMEOUT_RST;
      meas_len <= monitor_pkg::MEAS_PULSE_CYCLES_RST;
    end else if (req.wr) begin
      unique case (req.addr)
        monitor_pkg::REG_CTRL: ctrl <= req.wdata[5:0];
        monitor_pkg::REG_BAND: begin
          band_lower <= req.wdata[7:0];
          band_upper <= req.wdata[15:8];
        end
        monitor_pkg::REG_DIAG_DELAY: begin
          diag_delay <= (req.wdata > 16'(monitor_pkg::DIAG_DELAY_MAX)) ?
                        monitor_pkg::DIAG_DELAY_MAX : req.wdata[6:0];
        end
        monitor_pkg::REG_HEAT_TIMEOUT: heat_timeout <= req.wdata;
        monitor_pkg::REG_MEAS_PULSE: begin
          if (req.wdata != 16'h0) begin
            meas_len <= req.wdata;
          end
        end
        default: ;
      endcase
    end
  end
  monitor_pkg::hold_setting_t hold_setting;
  assign hold_setting = monitor_pkg::hold_setting_t'(ctrl[monitor_pkg::CTRL_HOLD_LSB +: 2]);

  // Measuring pulse generator
  logic [31:0] meas_cnt;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meas_cnt <= 32'h0;
      meas_pulse <= 1'b0;
    end else begin
      meas_cnt <= (meas_cnt == 32'(monitor_pkg::MEAS_PERIOD_CYCLES - 1)) ? 32'h0 :
                  meas_cnt + 32'h1;
      meas_pulse <= (meas_cnt < 32'(meas_len));
    end
  end

  // Hold display
  logic [TEMP_W-1:0] held_temp;
  logic held_valid;
  logic [7:0] hold_cnt;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      held_temp <= '0;
      held_valid <= 1'b0;
      hold_cnt <= 8'h0;
    end else if (phase_end) begin
      held_temp <= actual_temp;
      held_valid <= 1'b1;
      hold_cnt <= monitor_pkg::HOLD_EXT_TICKS;
    end else if (tick && hold_cnt != 8'h0) begin
      hold_cnt <= hold_cnt - 8'h1;
    end
  end
  logic [TEMP_W-1:0] shown_temp;
  always_comb begin
    shown_temp = actual_temp;
    if (hold_setting == monitor_pkg::HOLD_ON && held_valid) begin
      shown_temp = held_temp;
    end else if (hold_setting == monitor_pkg::EXTENDED_HOLD && hold_cnt != 8'h0) begin
      shown_temp = held_temp;
    end
  end

  // Phase compensation sequence
  monitor_pkg::comp_state_t comp_state;
  logic [7:0] comp_cnt;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      comp_state <= monitor_pkg::COMP_IDLE;
      comp_cnt <= 8'h0;
    end else begin
      unique case (comp_state)
        monitor_pkg::COMP_IDLE: begin
          if (zero_calibration_ok && ctrl[monitor_pkg::CTRL_COMP_EN]) begin
            comp_state <= monitor_pkg::COMP_WINDOW;
            comp_cnt <= monitor_pkg::COMP_WINDOW_TICKS;
          end
        end
        monitor_pkg::COMP_WINDOW: begin
          if (enter_press) begin
            comp_state <= monitor_pkg::COMP_RUN;
            comp_cnt <= monitor_pkg::COMP_RUN_TICKS;
          end else if (comp_cnt == 8'h0) begin
            comp_state <= monitor_pkg::COMP_HOME;
          end else if (tick) begin
            comp_cnt <= comp_cnt - 8'h1;
          end
        end
        monitor_pkg::COMP_RUN: begin
          if (comp_cnt == 8'h0) begin
            comp_state <= monitor_pkg::COMP_HOME;
          end else if (tick) begin
            comp_cnt <= comp_cnt - 8'h1;
          end
        end
        monitor_pkg::COMP_HOME: comp_state <= monitor_pkg::COMP_IDLE;
        default: comp_state <= monitor_pkg::COMP_IDLE;
      endcase
    end
  end
  logic comp_running;
  assign comp_running = (comp_state == monitor_pkg::COMP_RUN);
  logic [2:0] run_dots;
  always_comb begin
    if (comp_cnt > 8'(2 * monitor_pkg::COMP_RUN_TICKS / 3)) begin
      run_dots = 3'b001;
    end else if (comp_cnt > 8'(monitor_pkg::COMP_RUN_TICKS / 3)) begin
      run_dots = 3'b011;
    end else begin
      run_dots = 3'b111;
    end
  end

  // Temperature diagnosis
  logic [TEMP_W+1:0] lo_lim;
  logic [TEMP_W+1:0] hi_lim;
  logic [TEMP_W+1:0] act_x;
  assign act_x = {2'b00, actual_temp};
  assign lo_lim = {2'b00, set_temp} - {{(TEMP_W - 6){1'b0}}, band_lower};
  assign hi_lim = {2'b00, set_temp} + {{(TEMP_W - 6){1'b0}}, band_upper};
  logic below;
  logic above;
  assign below = lo_lim[TEMP_W+1] ? 1'b0 : (act_x < lo_lim);
  assign above = act_x > hi_lim;
  logic in_band;
  assign in_band = !below && !above;
  logic armed;
  logic delay_run;
  logic lower_seen;
  logic [6:0] delay_cnt;
  logic [9:0] diag_err;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      armed <= 1'b0;
      delay_run <= 1'b0;
      lower_seen <= 1'b0;
      delay_cnt <= 7'h0;
      diag_err <= monitor_pkg::ERR_NONE;
    end else if (!ctrl[monitor_pkg::CTRL_DIAG_EN] || (rkey_release)) begin
      armed <= 1'b0;
      delay_run <= 1'b0;
      lower_seen <= 1'b0;
      if (rkey_release) diag_err <= monitor_pkg::ERR_NONE;
    end else begin
      if (start_rise) begin
        lower_seen <= 1'b0;
        armed <= in_band && (diag_delay == 7'h0);
        delay_run <= in_band && (diag_delay != 7'h0);
        delay_cnt <= diag_delay;
      end else if (start && !armed && !delay_run && in_band) begin
        if (!lower_seen && diag_delay != 7'h0) begin
          lower_seen <= 1'b1;
          delay_run <= 1'b1;
          delay_cnt <= diag_delay;
        end else begin
          armed <= 1'b1;
        end
      end else if (delay_run) begin
        if (delay_cnt == 7'h0) begin
          delay_run <= 1'b0;
          armed <= in_band;
        end else if (tick) begin
          delay_cnt <= delay_cnt - 7'h1;
        end
      end
      if (armed && start && !in_band && diag_err == monitor_pkg::ERR_NONE) begin
        diag_err <= below ? monitor_pkg::ERR_LOW : monitor_pkg::ERR_HIGH;
      end
      if (start_fall) begin
        armed <= 1'b0;
        delay_run <= 1'b0;
        if (!armed && diag_err == monitor_pkg::ERR_NONE) begin
          diag_err <= below ? monitor_pkg::ERR_NOARM_LOW : monitor_pkg::ERR_NOARM_HIGH;
        end
      end
    end
  end

  // Heatup timeout
  logic [15:0] heat_cnt;
  logic heat_run;
  logic heat_err;
  logic reached;
  assign reached = (32'(actual_temp) * 32'd100) >= (32'(set_temp) * 32'd95);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      heat_cnt <= 16'h0;
      heat_run <= 1'b0;
      heat_err <= 1'b0;
    end else if (rkey_release) begin
      heat_run <= 1'b0;
      heat_err <= 1'b0;
    end else begin
      if (start_rise && ctrl[monitor_pkg::CTRL_HEATUP_EN]) begin
        heat_run <= 1'b1;
        heat_cnt <= 16'h0;
      end else if (heat_run) begin
        if (reached || !start) begin
          heat_run <= 1'b0;
        end else if (heat_cnt > heat_timeout) begin
          heat_err <= 1'b1;
          heat_run <= 1'b0;
        end else if (tick) begin
          heat_cnt <= heat_cnt + 16'h1;
        end
      end
    end
  end

  // Fault collection, latched until reset key release
  logic [9:0] ext_code;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_code <= monitor_pkg::ERR_NONE;
    end else if (ext_fault_valid) begin
      ext_code <= ext_fault_code;
    end else if (rkey_release) begin
      ext_code <= monitor_pkg::ERR_NONE;
    end
  end

  function automatic monitor_pkg::lamp_class_t classify(input logic [9:0] c);
    if ((c >= 10'd101 && c <= 10'd103) || c == 10'd107 || c == 10'd108 ||
        (c >= 10'd201 && c <= 10'd203) || (c >= 10'd307 && c <= 10'd310) ||
        c == 10'd801 || (c >= 10'd900 && c <= 10'd999)) begin
      return monitor_pkg::LAMP_STEADY;
    end else if (c >= 10'd111 && c <= 10'd114) begin
      return monitor_pkg::LAMP_SLOW;
    end else if ((c >= 10'd104 && c <= 10'd106) || c == 10'd211 || c == 10'd302 ||
                 c == 10'd303) begin
      return monitor_pkg::LAMP_FAST;
    end else begin
      return monitor_pkg::LAMP_OFF;
    end
  endfunction

  monitor_pkg::lamp_class_t cls_ext;
  monitor_pkg::lamp_class_t cls_diag;
  monitor_pkg::lamp_class_t worst;
  logic [9:0] active_code;
  assign cls_ext = classify(ext_code);
  assign cls_diag = classify(diag_err);
  always_comb begin
    worst = (cls_ext > cls_diag) ? cls_ext : cls_diag;
    if (heat_err && worst == monitor_pkg::LAMP_OFF) begin
      worst = monitor_pkg::LAMP_STEADY;
    end
    if (cls_diag == worst && diag_err != monitor_pkg::ERR_NONE) begin
      active_code = diag_err;
    end else if (ext_code != monitor_pkg::ERR_NONE) begin
      active_code = ext_code;
    end else if (heat_err) begin
      active_code = monitor_pkg::ERR_HEATUP;
    end else begin
      active_code = monitor_pkg::ERR_NONE;
    end
  end

  // Blink generators
  logic [31:0] fast_cnt;
  logic [31:0] slow_cnt;
  logic fast_ph;
  logic slow_ph;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fast_cnt <= 32'h0;
      slow_cnt <= 32'h0;
      fast_ph <= 1'b0;
      slow_ph <= 1'b0;
    end else begin
      fast_cnt <= (fast_cnt == 32'(monitor_pkg::FAST_HALF_CYCLES - 1)) ? 32'h0 :
                  fast_cnt + 32'h1;
      slow_cnt <= (slow_cnt == 32'(monitor_pkg::SLOW_HALF_CYCLES - 1)) ? 32'h0 :
                  slow_cnt + 32'h1;
      if (fast_cnt == 32'(monitor_pkg::FAST_HALF_CYCLES - 1)) fast_ph <= !fast_ph;
      if (slow_cnt == 32'(monitor_pkg::SLOW_HALF_CYCLES - 1)) slow_ph <= !slow_ph;
    end
  end

  // Registered outputs
  logic relay_raw;
  always_comb begin
    unique case (worst)
      monitor_pkg::LAMP_STEADY: relay_raw = 1'b1;
      monitor_pkg::LAMP_SLOW, monitor_pkg::LAMP_FAST: relay_raw = start;
      default: relay_raw = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      alarm_lamp <= 1'b0;
      alarm_relay <= 1'b0;
    end else begin
      unique case (worst)
        monitor_pkg::LAMP_STEADY: alarm_lamp <= 1'b1;
        monitor_pkg::LAMP_SLOW: alarm_lamp <= start | slow_ph;
        monitor_pkg::LAMP_FAST: alarm_lamp <= start | fast_ph;
        default: alarm_lamp <= 1'b0;
      endcase
      alarm_relay <= relay_raw ^ ctrl[monitor_pkg::CTRL_RELAY_INV];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      analog_out <= '0;
      heat_lamp <= 1'b0;
      display <= '0;
    end else begin
      analog_out <= comp_running ? '0 : actual_temp;
      heat_lamp <= comp_running && comp_cnt[1];
      display.code <= active_code;
      display.comp_window_prompt <= (comp_state == monitor_pkg::COMP_WINDOW) || comp_running;
      display.dots <= (comp_state == monitor_pkg::COMP_WINDOW) ? 3'b111 :
                      comp_running ? run_dots : 3'b000;
      display.temp <= 10'(shown_temp);
    end
  end

  // Register read port
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata <= 16'h0;
    end else if (req.rd) begin
      unique case (req.addr)
        monitor_pkg::REG_CTRL: rdata <= {10'h0, ctrl};
        monitor_pkg::REG_BAND: rdata <= {band_upper, band_lower};
        monitor_pkg::REG_DIAG_DELAY: rdata <= {9'h0, diag_delay};
        monitor_pkg::REG_HEAT_TIMEOUT: rdata <= heat_timeout;
        monitor_pkg::REG_MEAS_PULSE: rdata <= meas_len;
        monitor_pkg::REG_STATUS: rdata <= {armed, heat_err, worst, comp_state, active_code[7:0]};
        monitor_pkg::REG_DISPLAY: rdata <= {6'h0, active_code};
        default: rdata <= 16'h0;
      endcase
    end else begin
      rdata <= 16'h0;
    end
  end
endmodule

// File: verif/machine_ctrl_model.sv
// Machine controller model that drives the start input
module machine_ctrl_model (
  input logic ref_clk,
  input logic go,
  output logic start_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Start changes only after a clock edge, like a real controller output
  always @(posedge ref_clk) begin
    start_pin <= go;
  end
endmodule

// File: verif/heatseal_monitor_alarm_assertions.sv
// Port-level checks for the supervision and alarm block
module heatseal_checker #(
  parameter int unsigned TEMP_W = 10
) (
  input logic ref_clk,
  input logic rst_n,
  input logic start_pin,
  input logic reset_key,
  input logic [TEMP_W-1:0] actual_temp,
  input monitor_pkg::reg_req_t req,
  input logic [15:0] rdata,
  input monitor_pkg::display_t display,
  input logic [TEMP_W-1:0] analog_out,
  input logic meas_pulse,
  input logic alarm_lamp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic [15:0] hi_cnt;
  logic [15:0] len;
  logic blink;
  assign blink = display.code inside {[10'h068:10'h06a], [10'h06f:10'h072], 10'h0d3,
    10'h12e, 10'h12f};
  // Length of the running pulse against the last accepted setting
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hi_cnt <= 16'h0000;
      len <= monitor_pkg::MEAS_PULSE_CYCLES_RST;
    end else begin
      hi_cnt <= meas_pulse ? hi_cnt + 16'h0001 : 16'h0000;
      if (req.wr && req.addr == monitor_pkg::REG_MEAS_PULSE && req.wdata != 16'h0000) begin
        len <= req.wdata;
      end
    end
  end
  rdata_idle_a: assert property (!$past(req.rd) |-> rdata == 16'h0000)
    else $error("read data outside read cycle");
  pulse_len_a: assert property ($fell(meas_pulse) |-> hi_cnt == len)
    else $error("measuring pulse length wrong");
  analog_track_a: assert property ($past(rst_n, 2) && !display.comp_window_prompt
    && !$past(display.comp_window_prompt) |-> analog_out == $past(actual_temp))
    else $error("analog output not real time");
  comp_floor_a: assert property (display.comp_window_prompt && display.dots != 3'h7
    |-> analog_out == '0) else $error("analog output not at bottom");
  prompt_dots_a: assert property ($rose(display.comp_window_prompt) |-> display.dots == 3'h7)
    else $error("prompt without all dots");
  start_steady_a: assert property ((start_pin && blink) [*6] |-> alarm_lamp)
    else $error("lamp not steady under start");
  steady_lamp_a: assert property ((display.code inside {[10'h133:10'h136]}) [*3]
    |-> alarm_lamp) else $error("lamp not steady for diagnosis fault");
  key_hold_a: assert property ((reset_key && display.code != 10'h000) [*5]
    |=> display.code != 10'h000) else $error("alarm cleared while key held");
endmodule
bind heatseal_monitor_alarm heatseal_checker #(.TEMP_W(TEMP_W)) heatseal_checker_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .start_pin(start_pin), .reset_key(reset_key),
  .actual_temp(actual_temp), .req(req), .rdata(rdata), .display(display),
  .analog_out(analog_out), .meas_pulse(meas_pulse), .alarm_lamp(alarm_lamp));

// File: verif/tb_top.sv
// Self-checking bench for the supervision and alarm block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic enter_key = 1'b0;
  logic reset_key = 1'b0;
  logic phase_end = 1'b0;
  logic zc_ok = 1'b0;
  logic ef_valid = 1'b0;
  logic start_pin, meas_pulse, heat_lamp, alarm_lamp, alarm_relay;
  logic [9:0] act = 10'h0c8;
  logic [9:0] ef_code = 10'h000;
  logic [9:0] analog_out;
  logic [15:0] rdata, v;
  monitor_pkg::reg_req_t req = '0;
  monitor_pkg::display_t display;
  int n_errors = 0;
  int checks_done = 0;
  int hl = 0;
  logic [15:0] rst_tab [4] = '{16'h0000, 16'h0a0a, 16'h0000, 16'h0032};
  logic [9:0] codes [20] = '{10'h068, 10'h069, 10'h06a, 10'h0d3, 10'h12e, 10'h12f, 10'h06f,
    10'h070, 10'h071, 10'h072, 10'h065, 10'h066, 10'h067, 10'h06b, 10'h06c, 10'h0c9, 10'h0ca,
    10'h0cb, 10'h321, 10'h384};
  logic [1:0] cls [20] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h3,
    2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
  logic [9:0] d0 [4] = '{10'h0c8, 10'h0c8, 10'h096, 10'h0fa};
  logic [9:0] d1 [4] = '{10'h0bd, 10'h0d3, 10'h096, 10'h0fa};
  logic [9:0] de [4] = '{10'h133, 10'h134, 10'h135, 10'h136};
  heatseal_monitor_alarm #(.TICK_LEN(10)) heatseal_monitor_alarm_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .start_pin(start_pin), .enter_key(enter_key),
    .reset_key(reset_key), .actual_temp(act), .set_temp(10'h0c8), .phase_end(phase_end),
    .zero_calibration_ok(zc_ok), .ext_fault_code(ef_code), .ext_fault_valid(ef_valid),
    .req(req), .rdata(rdata), .display(display), .analog_out(analog_out),
    .meas_pulse(meas_pulse), .heat_lamp(heat_lamp), .alarm_lamp(alarm_lamp),
    .alarm_relay(alarm_relay));
  machine_ctrl_model machine_ctrl_model_inst (.ref_clk(ref_clk), .go(go),
    .start_pin(start_pin));
  initial forever #50 ref_clk = ~ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus access; read data is taken in the cycle after the strobe
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    req <= '{a, d, w, !w};
    cyc(1);
    req <= '0;
    #1 v = rdata;
    cyc(1);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    check($sformatf("reg %h", a), v, e);
  endtask
  task automatic wcode(input logic [9:0] e);
    for (int i = 0; i < 80 && display.code !== e; i++) cyc(1);
    check("code", 16'(display.code), 16'(e));
    if (display.code !== e) give_verdict();
  endtask
  task automatic flt(input logic [9:0] c);
    ef_code <= c;
    ef_valid <= 1'b1;
    cyc(1);
    ef_valid <= 1'b0;
    cyc(4);
  endtask
  task automatic zc;
    zc_ok <= 1'b1;
    cyc(1);
    zc_ok <= 1'b0;
    cyc(6);
  endtask
  task automatic clr;
    go <= 1'b0;
    reset_key <= 1'b1;
    cyc(6);
    reset_key <= 1'b0;
    cyc(8);
  endtask
  task automatic give_verdict;
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(3);
    rst_n <= 1'b1;
    bus(1'b1, monitor_pkg::REG_MEAS_PULSE, 16'h0064);
    bus(1'b1, monitor_pkg::REG_MEAS_PULSE, 16'h0000);
    rchk(monitor_pkg::REG_MEAS_PULSE, 16'h0064);
    for (int k = 0; k < 4; k++) rchk(4'(k), rst_tab[k]);
    bus(1'b1, 4'h7, 16'h00ff);
    rchk(4'h7, 16'h0000);
    bus(1'b1, monitor_pkg::REG_DIAG_DELAY, 16'h00c8);
    rchk(monitor_pkg::REG_DIAG_DELAY, 16'h0063);
    foreach (codes[k]) begin
      flt(codes[k]);
      bus(1'b0, monitor_pkg::REG_STATUS, 16'h0000);
      check("class", 16'(v[13:12]), 16'(cls[k]));
      check("relay", 16'(alarm_relay), 16'(cls[k] == 2'h3));
      check("shown", 16'(display.code), 16'(codes[k]));
      clr();
    end
    flt(10'h068);
    go <= 1'b1;
    cyc(8);
    check("lamp", 16'(alarm_lamp), 16'h0001);
    check("relay", 16'(alarm_relay), 16'h0001);
    bus(1'b1, monitor_pkg::REG_CTRL, 16'h0020);
    cyc(3);
    check("relay inv", 16'(alarm_relay), 16'h0000);
    clr();
    bus(1'b1, monitor_pkg::REG_CTRL, 16'h0008);
    bus(1'b1, monitor_pkg::REG_DIAG_DELAY, 16'h0000);
    foreach (d0[k]) begin
      flt(10'h06f);
      act <= d0[k];
      go <= 1'b1;
      cyc(8);
      act <= d1[k];
      cyc(8);
      go <= 1'b0;
      wcode(de[k]);
      check("relay", 16'(alarm_relay), 16'h0001);
      bus(1'b0, monitor_pkg::REG_STATUS, 16'h0000);
      check("worst", 16'(v[13:12]), 16'h0003);
      act <= 10'h0c8;
      clr();
    end
    bus(1'b1, monitor_pkg::REG_DIAG_DELAY, 16'h0005);
    act <= 10'h096;
    go <= 1'b1;
    cyc(6);
    act <= 10'h0c8;
    cyc(25);
    bus(1'b0, monitor_pkg::REG_STATUS, 16'h0000);
    check("armed early", 16'(v[15]), 16'h0000);
    cyc(40);
    bus(1'b0, monitor_pkg::REG_STATUS, 16'h0000);
    check("armed late", 16'(v[15]), 16'h0001);
    clr();
    bus(1'b1, monitor_pkg::REG_CTRL, 16'h0010);
    bus(1'b1, monitor_pkg::REG_HEAT_TIMEOUT, 16'h0003);
    act <= 10'h0be;
    go <= 1'b1;
    cyc(60);
    check("heat ok", 16'(display.code), 16'h0000);
    clr();
    act <= 10'h0bd;
    go <= 1'b1;
    wcode(10'h130);
    clr();
    bus(1'b1, monitor_pkg::REG_CTRL, 16'h0000);
    zc();
    check("no window", 16'(display.comp_window_prompt), 16'h0000);
    bus(1'b1, monitor_pkg::REG_CTRL, 16'h0004);
    zc();
    check("window", 16'(display.comp_window_prompt), 16'h0001);
    check("dots", 16'(display.dots), 16'h0007);
    cyc(250);
    check("home", 16'(display.comp_window_prompt), 16'h0000);
    zc();
    enter_key <= 1'b1;
    cyc(5);
    enter_key <= 1'b0;
    act <= 10'h07b;
    for (int i = 0; i < 100; i++) begin
      cyc(1);
      hl += 32'(heat_lamp);
    end
    check("run", 16'(display.comp_window_prompt), 16'h0001);
    check("floor", 16'(analog_out), 16'h0000);
    check("run dots", 16'(display.dots), 16'h0003);
    check("blink", 16'(hl > 0 && hl < 100), 16'h0001);
    cyc(300);
    check("done", 16'(display.comp_window_prompt), 16'h0000);
    bus(1'b1, monitor_pkg::REG_CTRL, 16'h0002);
    act <= 10'h064;
    cyc(2);
    phase_end <= 1'b1;
    cyc(1);
    phase_end <= 1'b0;
    act <= 10'h096;
    cyc(100);
    check("held", 16'(display.temp), 16'h0064);
    check("analog", 16'(analog_out), 16'h0096);
    cyc(250);
    check("live", 16'(display.temp), 16'h0096);
    bus(1'b1, monitor_pkg::REG_CTRL, 16'h0001);
    cyc(2);
    check("hold on", 16'(display.temp), 16'h0064);
    give_verdict();
  end
endmodule
